// ### pkg/adcc_pkg.sv
package adcc_pkg;
  // converter sequencer states
  typedef enum logic [1:0] {
    ADCC_IDLE    = 2'b00,
    ADCC_SAMPLE  = 2'b01,
    ADCC_CONVERT = 2'b10
  } adcc_sar_state_t;
endpackage

// ### pkg/adcc_regs.svh
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ADCC_OFF_MODE    8'h00
`define ADCC_OFF_START   8'h04
`define ADCC_OFF_RESULT  8'h08
`define ADCC_OFF_CTRL    8'h0c

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ADCC_MODE_CKS    7
`define ADCC_MODE_EXT_TRIGGER_ENABLE   6
`define ADCC_START_ACT   7
`define ADCC_CTRL_PINSEL 0
`define ADCC_CTRL_EDGE   1
`define ADCC_CTRL_IEN    2
`define ADCC_CTRL_DONE   3

// ----------------------------------------------------------------------
// reset values and fixed read bits
// ----------------------------------------------------------------------
`define ADCC_MODE_RST    8'h30
`define ADCC_START_ONES  7'h7f
`define ADCC_CH_RST      4'h0

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define ADCC_CLK_MHZ     10
`define ADCC_DIV4_LIM    2'h3
`define ADCC_DIV2_LIM    2'h1
`define ADCC_SAMPLE_TKS  2'h3
`define ADCC_STATES_DIV4 62
`define ADCC_STATES_DIV2 31
`define ADCC_RES_BITS    10

`endif

// ### rtl/adcc_sar.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcc_regs.svh"

module adcc_sar (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // sequencing
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       comp,
  // results
  output logic            busy,
  output logic            done,
  output logic            sample_en,
  output logic [9:0]      code,
  output logic [9:0]      result
);

  adcc_pkg::adcc_sar_state_t state_reg;  // sequencer state
  logic [1:0]  smp_reg;                  // sample tick count
  logic [3:0]  bit_reg;                  // bit under trial
  logic [9:0]  trial_next;               // code after this tick
  logic        last_tick;                // final bit decided now

  assign busy      = (state_reg != adcc_pkg::ADCC_IDLE);
  assign last_tick = (state_reg == adcc_pkg::ADCC_CONVERT) && tick
                     && (bit_reg == 4'h0) && !abort;

  // ----------------------------------------------------------------------
  // per bit trial: keep or drop current bit, raise the next one
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `ADCC_RES_BITS; i = i + 1) begin : g_bit
      assign trial_next[i] = (bit_reg == 4'(i))     ? comp :
                             (bit_reg == 4'(i + 1)) ? 1'b1 : code[i];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // sequencer: sample window then ten binary-search steps
  // ----------------------------------------------------------------------
  // ten bit search
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= adcc_pkg::ADCC_IDLE;
      smp_reg   <= 2'h0;
      bit_reg   <= 4'h9;
      code      <= 10'h000;
      sample_en <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= last_tick;
      unique case (state_reg)
        adcc_pkg::ADCC_IDLE: begin
          if (start) begin
            state_reg <= adcc_pkg::ADCC_SAMPLE;
            smp_reg   <= 2'h0;
            sample_en <= 1'b1;
          end
        end
        adcc_pkg::ADCC_SAMPLE: begin
          if (abort) begin
            state_reg <= adcc_pkg::ADCC_IDLE;
            sample_en <= 1'b0;
          end else if (tick && smp_reg == `ADCC_SAMPLE_TKS) begin
            state_reg <= adcc_pkg::ADCC_CONVERT;
            sample_en <= 1'b0;
            bit_reg   <= 4'h9;
            code      <= 10'h200;
          end else if (tick) begin
            smp_reg <= smp_reg + 2'h1;
          end
        end
        adcc_pkg::ADCC_CONVERT: begin
          if (abort) begin
            state_reg <= adcc_pkg::ADCC_IDLE;
          end else if (tick) begin
            code <= trial_next;
            if (bit_reg == 4'h0) begin
              state_reg <= adcc_pkg::ADCC_IDLE;
            end else begin
              bit_reg <= bit_reg - 4'h1;
            end
          end
        end
        default: begin
          state_reg <= adcc_pkg::ADCC_IDLE;
        end
      endcase
    end
  end

  // final code, no reset so it survives a system reset
  always_ff @(posedge clk) begin
    if (last_tick) begin
      result <= trial_next;
    end
  end

  conv_steps_a: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> $past(bit_reg) == 4'h0 && !busy)
    else $error("completion without finishing all ten bits");

endmodule
`default_nettype wire

// ### rtl/adcc_top.sv
// Function
// - produce ten bit successive approximation results
// - writing start bit begins selected channel
// - store converted value in result register
// - completion sets done flag, optional interrupt
// - active flag high throughout, cleared after
// - result, done, active change together
// - pin trigger needs both enables set
// - selected pin edge sets active, converts
// - reset initialises; low power retains registers
// - result survives reset except power on
// - writing zero aborts a running conversion
// - channel codes decode, others select none
// - clock divide four or two, bounded
// - result held left aligned until next completion
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "adcc_regs.svh"

module adcc_top (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // power mode: high in watch, standby and similar modes
  input  wire logic        LOW_POWER,
  // analog front end and trigger pin
  input  wire logic        COMP_IN,
  input  wire logic        EXT_TRIG,
  output logic      [7:0]  CHAN_EN,
  output logic      [9:0]  DAC_CODE,
  output logic             SAMPLE_EN,
  // conversion end request
  output logic             IRQ
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic        cks_reg;        // conv clock select
  logic        ext_trigger_enable_reg;       // ext trigger enable
  logic [3:0]  ch_reg;         // channel select
  logic        active_reg;     // conversion active flag
  logic [15:0] result_reg;     // left aligned result
  logic        pinsel_reg;     // trigger pin select
  logic        edge_reg;       // trigger edge select, 1 falling
  logic        ien_reg;        // done interrupt enable
  logic        done_reg;       // conversion done flag
  logic        wr_pend_reg;    // write data phase pending
  logic [7:0]  addr_reg;       // data phase address
  logic [1:0]  div_reg;        // conversion clock divider
  logic [2:0]  trig_sync_reg;  // trigger pin sync chain
  logic        comp_sync_reg;  // comparator capture flop
  logic [7:0]  chan_reg;       // one-hot channel enables
  logic        irq_reg;        // interrupt request pulse

  // sar engine outputs
  logic        sar_busy;
  logic        sar_done;
  logic [9:0]  sar_result;

  // ----------------------------------------------------------------------
  // channel decode
  // ----------------------------------------------------------------------
  // channel code decode
  function automatic logic [7:0] chan_decode(input logic [3:0] c);
    logic [7:0] oh;
    oh = 8'h00;
    // 00xx selects nothing; 11xx is prohibited and also selects nothing
    if (c >= 4'h4 && c <= 4'hb) begin
      oh = 8'h01 << (c - 4'h4);
    end
    return oh;
  endfunction

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire       addr_phase = HSEL && HTRANS[1] && HREADY;
  // low power freezes register contents, so writes are dropped there
  wire       wr_en      = wr_pend_reg && !LOW_POWER;
  wire       wr_mode    = wr_en && addr_reg == `ADCC_OFF_MODE;
  wire       wr_start   = wr_en && addr_reg == `ADCC_OFF_START;
  wire       wr_ctrl    = wr_en && addr_reg == `ADCC_OFF_CTRL;
  wire [7:0] rd_addr    = HADDR[7:0];

  wire [31:0] rd_mode   = {24'h000000, cks_reg, ext_trigger_enable_reg, 2'b11, ch_reg};
  wire [31:0] rd_start  = {24'h000000, active_reg, `ADCC_START_ONES};
  wire [31:0] rd_result = {16'h0000, result_reg};
  wire [31:0] rd_ctrl   = {28'h0000000, done_reg, ien_reg, edge_reg,
                           pinsel_reg};
  wire [31:0] rd_next   = (rd_addr == `ADCC_OFF_MODE)   ? rd_mode   :
                          (rd_addr == `ADCC_OFF_START)  ? rd_start  :
                          (rd_addr == `ADCC_OFF_RESULT) ? rd_result :
                          (rd_addr == `ADCC_OFF_CTRL)   ? rd_ctrl   :
                          32'h00000000;

  // ----------------------------------------------------------------------
  // start, abort and trigger decode
  // ----------------------------------------------------------------------
  // edge to pulse
  wire trig_rise = trig_sync_reg[1] && !trig_sync_reg[2];
  wire trig_fall = !trig_sync_reg[1] && trig_sync_reg[2];
  wire trig_edge = edge_reg ? trig_fall : trig_rise;
  wire trig_ok   = pinsel_reg && ext_trigger_enable_reg;
  wire sw_start  = wr_start && HWDATA[`ADCC_START_ACT];
  wire sw_abort  = wr_start && !HWDATA[`ADCC_START_ACT] && active_reg;
  wire start_go  = !active_reg && !LOW_POWER
                   && (sw_start || (trig_ok && trig_edge));
  wire [1:0] div_lim = cks_reg ? `ADCC_DIV2_LIM : `ADCC_DIV4_LIM;
  wire conv_tick = active_reg && !LOW_POWER && div_reg == div_lim;

  // ----------------------------------------------------------------------
  // bus slave: zero wait, always okay
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      HRDATA      <= 32'h00000000;
      HREADYOUT   <= 1'b1;
      HRESP       <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && HWRITE;
      if (addr_phase) begin
        addr_reg <= HADDR[7:0];
      end
      // read data captured at the address phase edge
      if (addr_phase && !HWRITE) begin
        HRDATA <= rd_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode and control registers
  // ----------------------------------------------------------------------
  // reset init, write freeze
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cks_reg    <= 1'b0;
      ext_trigger_enable_reg   <= 1'b0;
      ch_reg     <= `ADCC_CH_RST;
      pinsel_reg <= 1'b0;
      edge_reg   <= 1'b0;
      ien_reg    <= 1'b0;
    end else begin
      if (wr_mode) begin
        cks_reg  <= HWDATA[`ADCC_MODE_CKS];
        ext_trigger_enable_reg <= HWDATA[`ADCC_MODE_EXT_TRIGGER_ENABLE];
        ch_reg   <= HWDATA[3:0];
      end
      if (wr_ctrl) begin
        pinsel_reg <= HWDATA[`ADCC_CTRL_PINSEL];
        edge_reg   <= HWDATA[`ADCC_CTRL_EDGE];
        ien_reg    <= HWDATA[`ADCC_CTRL_IEN];
      end
    end
  end

  // ----------------------------------------------------------------------
  // active flag, done flag, interrupt pulse
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      active_reg <= 1'b0;
      done_reg   <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      if (start_go) begin
        active_reg <= 1'b1;
      end else if (sar_done || sw_abort) begin
        active_reg <= 1'b0;
      end
      if (sar_done) begin
        done_reg <= 1'b1;
      end else if (wr_ctrl && HWDATA[`ADCC_CTRL_DONE]) begin
        done_reg <= 1'b0;
      end
      irq_reg <= sar_done && ien_reg;
    end
  end

  // ----------------------------------------------------------------------
  // result register: no reset, so a warm reset leaves it intact
  // ----------------------------------------------------------------------
  // load on completion
  always_ff @(posedge CLK_SYS) begin
    if (sar_done) begin
      result_reg <= {sar_result, 6'h00};
    end
  end

  // ----------------------------------------------------------------------
  // divider, synchronisers, channel enables
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      div_reg       <= 2'h0;
      trig_sync_reg <= 3'h0;
      comp_sync_reg <= 1'b0;
      chan_reg      <= 8'h00;
    end else begin
      if (start_go || conv_tick) begin
        div_reg <= 2'h0;
      end else if (active_reg && !LOW_POWER) begin
        div_reg <= div_reg + 2'h1;
      end
      trig_sync_reg <= {trig_sync_reg[1:0], EXT_TRIG};
      // comparator settles from our own code register, so one capture
      // flop; a second would hand the divide-by-two rate a stale bit
      comp_sync_reg <= COMP_IN;
      if (start_go) begin
        chan_reg <= chan_decode(ch_reg);
      end else if (sar_done || sw_abort) begin
        chan_reg <= 8'h00;
      end
    end
  end

  assign CHAN_EN = chan_reg;
  assign IRQ     = irq_reg;

  // ----------------------------------------------------------------------
  // successive approximation engine
  // ----------------------------------------------------------------------
  adcc_sar u_sar (
    .clk       (CLK_SYS),
    .rst_n     (RSTN),
    .tick      (conv_tick),
    .start     (start_go),
    .abort     (sw_abort),
    .comp      (comp_sync_reg),
    .busy      (sar_busy),
    .done      (sar_done),
    .sample_en (SAMPLE_EN),
    .code      (DAC_CODE),
    .result    (sar_result)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // cycles spent converting, frozen in low power
  logic [6:0] conv_cnt;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      conv_cnt <= 7'h00;
    end else if (!active_reg) begin
      conv_cnt <= 7'h00;
    end else if (!LOW_POWER) begin
      conv_cnt <= conv_cnt + 7'h01;
    end
  end

  done_step_a: assert property (
    sar_done |=> done_reg && !active_reg && $fell(active_reg))
    else $error("completion step incomplete");
  result_load_a: assert property (
    sar_done |=> result_reg == {$past(sar_result), 6'h00})
    else $error("result not loaded left aligned");
  irq_gate_a: assert property (
    ##1 IRQ == $past(sar_done && ien_reg))
    else $error("interrupt request does not follow completion");
  trig_block_a: assert property (
    !active_reg && !trig_ok && !sw_start |=> !active_reg)
    else $error("conversion started with trigger disabled");
  trig_start_a: assert property (
    trig_ok && trig_edge && !active_reg && !LOW_POWER |=> active_reg)
    else $error("enabled trigger edge did not start");
  abort_now_a: assert property (
    // done flag is sticky: only a fresh rise after abort is wrong
    sw_abort |=> !active_reg && !sar_busy
                 && ($past(sar_done) || !$rose(done_reg)))
    else $error("abort did not stop conversion");
  busy_hold_a: assert property (
    active_reg && !sar_done && !sw_abort |=> active_reg)
    else $error("active flag dropped mid conversion");
  chan_none_a: assert property (
    start_go && ch_reg[3:2] != 2'b01 && ch_reg[3:2] != 2'b10
    |=> CHAN_EN == 8'h00)
    else $error("invalid channel code enabled an input");
  conv_len_a: assert property (
    active_reg |-> conv_cnt <= (cks_reg ? 7'd31 : 7'd62))
    else $error("conversion exceeded its state budget");
  result_hold_a: assert property (
    !sar_done |=> $stable(result_reg))
    else $error("result changed without completion");
  lp_hold_a: assert property (
    LOW_POWER |=> $stable(ch_reg) && $stable(cks_reg) && $stable(ien_reg))
    else $error("register changed in low power mode");

endmodule
`default_nettype wire

// ### verification/adcc_analog_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// analog inputs and trigger source seen by the converter
// ----------------------------------------------------------------------
module adcc_analog_model (
  // clock for the floating comparator pattern
  input  wire logic            clk,
  // levels chosen by the bench
  input  wire logic [7:0][9:0] level,
  input  wire logic            trig_lvl,
  // converter side
  input  wire logic [7:0]      chan_en,
  input  wire logic [9:0]      dac_code,
  output logic                 comp_in,
  output logic                 ext_trig
);
  logic       float_reg = 1'b0; // no input enabled: comparator floats
  logic [9:0] sel_level;        // level of the enabled input

  // floating node toggles so a stale value never looks valid
  always @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  // pick the enabled input, one-hot from the converter
  always_comb begin
    sel_level = 10'h000;
    for (int i = 0; i < 8; i++) begin
      if (chan_en[i]) begin
        sel_level = level[i];
      end
    end
  end

  // ideal comparator, combinational so both dividers are safe
  assign comp_in = (chan_en == 8'h00) ? float_reg : (sel_level >= dac_code);

  // pin level only moves when the bench says so
  assign ext_trig = trig_lvl;
endmodule

`default_nettype wire

// ### verification/adcc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "adcc_regs.svh"

module adcc_top_tb;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic            clk_sys = 1'b0;
  logic            rstn, hsel, hwrite, low_power, trig_lvl;
  logic [1:0]      htrans;
  logic [31:0]     haddr, hwdata, hrdata, rd;
  logic            hreadyout, hresp, comp_in, ext_trig, sample_en, irq;
  logic [7:0]      chan_en;
  logic [9:0]      dac_code;
  logic [7:0][9:0] level;
  integer          num_errors = 0, tests_run = 0, seed = 32'h6d23;
  integer          cyc = 0, irq_cnt = 0, irq_cyc = 0, k, ch;
  // reference model state
  logic [7:0]      exp_mode, exp_ctrl;
  logic [31:0]     exp_res;
  logic            exp_act;

  always #50 clk_sys = ~clk_sys;

  // cycle count and conversion end monitor
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
      irq_cyc <= cyc;
    end
  end

  adcc_top uut (.CLK_SYS(clk_sys), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HREADY(hreadyout),
    .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .LOW_POWER(low_power), .COMP_IN(comp_in), .EXT_TRIG(ext_trig),
    .CHAN_EN(chan_en), .DAC_CODE(dac_code), .SAMPLE_EN(sample_en),
    .IRQ(irq));

  adcc_analog_model partner (.clk(clk_sys), .level(level),
    .trig_lvl(trig_lvl), .chan_en(chan_en), .dac_code(dac_code),
    .comp_in(comp_in), .ext_trig(ext_trig));

  // ----------------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  function automatic logic [31:0] model_rd(input logic [7:0] off);
    case (off)
      `ADCC_OFF_MODE:   model_rd = {24'h0, exp_mode};
      `ADCC_OFF_START:  model_rd = {24'h0, exp_act, `ADCC_START_ONES};
      `ADCC_OFF_RESULT: model_rd = exp_res;
      `ADCC_OFF_CTRL:   model_rd = {24'h0, exp_ctrl};
      default:          model_rd = 32'h0;
    endcase
  endfunction

  // write, mirrored in the model unless the block is frozen
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    bus(off, 1'b1, {24'h0, d}, rd);
    if (low_power !== 1'b1) begin
      case (off)
        `ADCC_OFF_MODE:  exp_mode = (d & 8'hcf) | `ADCC_MODE_RST;
        `ADCC_OFF_START: exp_act = d[7];
        `ADCC_OFF_CTRL:  exp_ctrl = {4'h0, exp_ctrl[3] & ~d[3], d[2:0]};
        default: ;
      endcase
    end
  endtask

  task automatic rc(input logic [7:0] off);
    bus(off, 1'b0, 32'h0, rd);
    check(rd, model_rd(off));
  endtask

  // poll until idle, then account for the completion in the model
  task automatic wait_idle(input logic [3:0] code);
    k = 0;
    do begin
      bus(`ADCC_OFF_START, 1'b0, 32'h0, rd);
      k = k + 1;
    end while (rd[7] !== 1'b0 && k < 60);
    repeat (3) @(posedge clk_sys);
    exp_act = 1'b0;
    exp_ctrl[3] = 1'b1;
    rc(`ADCC_OFF_START);
    rc(`ADCC_OFF_CTRL);
    if (code[3:2] == 2'b01 || code[3:2] == 2'b10) begin
      exp_res = {16'h0, level[code[2:0] - 3'd4], 6'h00};
      rc(`ADCC_OFF_RESULT);
    end
  endtask

  // software started conversion, optionally with the start bit written again while busy (ignored, no restart)
  task automatic conv(input logic [3:0] code, input logic conv_clock_select,
                      input logic ien, input logic again);
    integer     t0, n0, lim;
    logic [7:0] exp_ch;
    lim = conv_clock_select ? `ADCC_STATES_DIV2 : `ADCC_STATES_DIV4;
    exp_ch = (code[3:2] == 2'b01 || code[3:2] == 2'b10) ?
             8'h01 << (code[2:0] - 3'd4) : 8'h00;
    wr(`ADCC_OFF_MODE, {conv_clock_select, 3'b011, code});
    wr(`ADCC_OFF_CTRL, {5'h01, ien, 2'b00});
    n0 = irq_cnt;
    wr(`ADCC_OFF_START, 8'h80);
    t0 = cyc;
    rc(`ADCC_OFF_START);
    check({24'h0, chan_en}, {24'h0, exp_ch});
    check({31'h0, sample_en}, 32'h1);
    check({31'h0, hresp}, 32'h0);
    if (again) begin
      wr(`ADCC_OFF_START, 8'h80);
    end
    wait_idle(code);
    check(irq_cnt - n0, {31'h0, ien});
    if (ien) begin
      check(32'(irq_cyc - t0 <= lim + 2), 32'h1);
    end
  endtask

  // pin edge with a given enable set; starts only when all agree
  task automatic trig_case(input logic pinsel, input logic ext_trigger_enable,
                           input logic edge_sel, input logic lvl0);
    trig_lvl <= lvl0;
    repeat (5) @(posedge clk_sys);
    wr(`ADCC_OFF_MODE, {1'b1, ext_trigger_enable, 6'h34});
    wr(`ADCC_OFF_CTRL, {6'h02, edge_sel, pinsel});
    trig_lvl <= ~lvl0;
    repeat (6) @(posedge clk_sys);
    exp_act = pinsel & ext_trigger_enable & (edge_sel == lvl0);
    rc(`ADCC_OFF_START);
    if (exp_act) begin
      wait_idle(4'h4);
    end
    wr(`ADCC_OFF_CTRL, 8'h08);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond the expected thousand or so cycles
  initial begin
    #(30000 * 100);
    num_errors = num_errors + 1;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    low_power = 1'b0;
    trig_lvl = 1'b0;
    for (k = 0; k < 8; k++) begin
      level[k] = 10'($random(seed));
    end
    level[0] = 10'h3ff;
    level[7] = 10'h000;
    exp_mode = `ADCC_MODE_RST;
    exp_ctrl = 8'h00;
    exp_act = 1'b0;
    exp_res = 32'h0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rc(`ADCC_OFF_MODE);
    rc(`ADCC_OFF_START);
    wr(8'h10, 8'hff);
    rc(8'h10);
    $display("test reset values done");
    for (ch = 0; ch < 8; ch++) begin
      conv(4'(ch + 4), ch[0], 1'b1, ch == 3);
    end
    for (ch = 0; ch < 4; ch++) begin
      conv({ch[1], ch[1], ch[0], ch[0]}, 1'b1, 1'b0, 1'b0);
    end
    $display("test conversions done");
    wr(`ADCC_OFF_CTRL, 8'h0c);
    k = irq_cnt;
    wr(`ADCC_OFF_START, 8'h80);
    wr(`ADCC_OFF_START, 8'h00);
    rc(`ADCC_OFF_START);
    repeat (`ADCC_STATES_DIV4 + 10) @(posedge clk_sys);
    rc(`ADCC_OFF_CTRL);
    check(irq_cnt, k);
    $display("test abort done");
    trig_case(1'b1, 1'b0, 1'b0, 1'b0);
    trig_case(1'b0, 1'b1, 1'b0, 1'b0);
    trig_case(1'b1, 1'b1, 1'b0, 1'b0);
    trig_case(1'b1, 1'b1, 1'b1, 1'b0);
    trig_case(1'b1, 1'b1, 1'b1, 1'b1);
    trig_case(1'b1, 1'b1, 1'b0, 1'b1);
    $display("test trigger done");
    conv(4'h6, 1'b0, 1'b1, 1'b0);
    low_power <= 1'b1;
    @(posedge clk_sys);
    wr(`ADCC_OFF_MODE, 8'h85);
    wr(`ADCC_OFF_START, 8'h80);
    rc(`ADCC_OFF_MODE);
    rc(`ADCC_OFF_START);
    rc(`ADCC_OFF_RESULT);
    low_power <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rc(`ADCC_OFF_MODE);
    $display("test low power done");
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    exp_mode = `ADCC_MODE_RST;
    exp_ctrl = 8'h00;
    exp_act = 1'b0;
    rc(`ADCC_OFF_RESULT);
    rc(`ADCC_OFF_MODE);
    rc(`ADCC_OFF_START);
    $display("test warm reset done");
    end_of_test();
  end
endmodule

`default_nettype wire
